/* verification/cm_far_side.sv */
// Far-side model: the clock pins that the clock manager watches.
// Assumes the bench flips the run controls just after mclk edges.
`timescale 1ns/1ps
module cm_far_side (
   input  wire logic ref_run,   // Reference clock toggles
   input  wire logic fb_conn,   // Feedback path connected
   input  wire logic fs_run,    // Synthesizer output toggles
   output logic      ref_clk,   // To ref_clock_input
   output logic      fb_clk,    // To feedback_clock_input
   output logic      fx_clk,    // To synth_clock_output
   output logic      fx_clk_n   // To synth_clock_output_inverted
);
   logic ref_osc = 1'b0;        // Free oscillator, unrelated to mclk
   logic fx_osc  = 1'b0;        // Synthesizer oscillator
   initial forever #41 ref_osc = ~ref_osc;
   initial forever #17 fx_osc = ~fx_osc;
   // A stopped clock parks low; feedback is a zero-lag copy of the reference
   assign ref_clk  = ref_osc & ref_run;
   assign fb_clk   = ref_clk & fb_conn;
   assign fx_clk   = fx_osc & fs_run;
   assign fx_clk_n = ~fx_osc & fs_run;
endmodule // cm_far_side

/* verification/cm_lock_status_bench.sv */
// Self-checking bench of the clock manager lock and status block.
// Assumes cm_far_side drives the clock pins and the bench is Avalon master.
`timescale 1ns/1ps
module cm_lock_status_bench;
   import cm_pkg::*;
   logic mclk, reset_n, cm_reset, ps_step, ps_increment, read, write;
   logic ref_run, fb_conn, fs_run, rc, fc, sc, sc_n, waitrequest;
   logic lock_indicator, user_mode, irq;
   logic [4:0]  address;
   logic [31:0] writedata, readdata, q;
   logic [7:0]  status;
   int          n_mismatch, num_checks, k;

   cm_far_side far (.ref_run(ref_run), .fb_conn(fb_conn), .fs_run(fs_run),
      .ref_clk(rc), .fb_clk(fc), .fx_clk(sc), .fx_clk_n(sc_n));
   cm_lock_status uut (.mclk(mclk), .reset_n(reset_n), .cm_reset(cm_reset),
      .ref_clock_input(rc), .feedback_clock_input(fc), .synth_clock_output(sc),
      .synth_clock_output_inverted(sc_n), .ps_step(ps_step),
      .ps_increment(ps_increment), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .lock_indicator(lock_indicator),
      .status(status), .user_mode(user_mode), .irq(irq));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask
   // One bus access; held until waitrequest is sampled low, the watchdog ends a hang
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      address <= a; writedata <= d; read <= ~w; write <= w;
      @(posedge mclk);
      while (waitrequest !== 1'b0)
      begin
         @(posedge mclk);
      end
      q = readdata;
      read <= 1'b0; write <= 1'b0;
      @(posedge mclk);
   endtask
   // Wait up to n edges for bit b of the status bus to reach v
   task automatic wait_sb(input int b, input logic v, input int n);
      for (k = 0; k < n && status[b] !== v; k++) @(posedge mclk);
   endtask
   task automatic step(input logic inc);
      ps_step <= 1'b1; ps_increment <= inc;
      @(posedge mclk);
      ps_step <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic pulse_cm_reset;
      cm_reset <= 1'b1;
      @(posedge mclk);
      chk({user_mode, lock_indicator, status}, 0, "cm_reset state");
      cm_reset <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset_and_lock;
      chk({irq, waitrequest, status}, 9'h100, "reset outputs");
      bus(1'b0, CM_OFS_CTRL, 0);
      chk(q, 32'h0000000e, "ctrl reset value");
      bus(1'b0, 5'h1c, 0);
      chk(q, 0, "unmapped read");
      for (k = 0; k < 600 && lock_indicator !== 1'b1; k++) @(posedge mclk);
      chk(lock_indicator, 1'b1, "lock on aligned clocks");
      chk(status, 8'h00, "status with all running");
      bus(1'b0, CM_OFS_STATUS, 0);
      chk(q, 32'h00000100, "status register with lock");
   endtask
   task automatic t_ref_stop;
      ref_run <= 1'b0;
      wait_sb(CM_SB_REF_STOP, 1'b1, 300);
      chk(status, 8'h02, "ref stopped flag");
      ref_run <= 1'b1;
      wait_sb(CM_SB_REF_STOP, 1'b0, 300);
      chk(status[1], 1'b0, "ref toggling again");
      // Synthesizer-only outputs: no flag on a stopped reference
      bus(1'b1, CM_OFS_CTRL, 32'h0000000a);
      ref_run <= 1'b0;
      repeat (300) @(posedge mclk);
      chk(status[1], 1'b0, "fs-only ref stop silent");
      ref_run <= 1'b1;
      bus(1'b1, CM_OFS_CTRL, 32'h0000000e);
   endtask
   task automatic t_synth_stop_irq;
      bus(1'b0, CM_OFS_IRQ_STAT, 0);
      chk(irq, 1'b0, "masked events give no irq");
      bus(1'b1, CM_OFS_IRQ_MASK, 32'h00000010);
      fs_run <= 1'b0;
      wait_sb(CM_SB_FS_STOP, 1'b1, 300);
      chk(status[2], 1'b1, "synth stopped flag");
      repeat (3) @(posedge mclk);
      chk(irq, 1'b1, "irq on unmasked event");
      bus(1'b0, CM_OFS_IRQ_STAT, 0);
      chk(q & 32'h10, 32'h10, "sticky synth stop event");
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0, "irq cleared by read");
      fs_run <= 1'b1;
      wait_sb(CM_SB_FS_STOP, 1'b0, 300);
      chk(status[2], 1'b0, "synth toggling again");
   endtask
   task automatic t_phase_overflow;
      repeat (255) step(1'b1);
      chk(status[0], 1'b0, "shift at 255/256");
      step(1'b1);
      chk(status[0], 1'b1, "shift past 255/256");
      step(1'b0);
      chk(status[0], 1'b0, "back within range");
   endtask
   task automatic t_startup;
      fb_conn <= 1'b0;
      pulse_cm_reset();
      bus(1'b0, CM_OFS_PHASE, 0);
      chk(q, 0, "taps and shift cleared by reset");
      // Wait option FALSE: user mode arrives without lock
      bus(1'b1, CM_OFS_CTRL, 32'h0000008e);
      for (k = 0; k < 100 && user_mode !== 1'b1; k++) @(posedge mclk);
      chk({user_mode, lock_indicator}, 2'b10, "no wait without option");
      pulse_cm_reset();
      // Wait option TRUE, hold at startup cycle 2
      bus(1'b1, CM_OFS_CTRL, 32'h000000af);
      repeat (150) @(posedge mclk);
      chk(user_mode, 1'b0, "stalled awaiting lock");
      fb_conn <= 1'b1;
      for (k = 0; k < 800 && user_mode !== 1'b1; k++) @(posedge mclk);
      chk({user_mode, lock_indicator}, 2'b11, "resumed after lock");
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Watchdog: the run needs some 2000 cycles
   initial
   begin
      #200000;
      n_mismatch++;
      wrap_up();
   end
   initial
   begin
      n_mismatch = 0; num_checks = 0;
      reset_n = 1'b0; cm_reset = 1'b0; ps_step = 1'b0; ps_increment = 1'b0;
      read = 1'b0; write = 1'b0; address = 5'h00; writedata = 32'h0;
      ref_run = 1'b1; fb_conn = 1'b1; fs_run = 1'b1;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      t_reset_and_lock();
      t_ref_stop();
      t_synth_stop_irq();
      t_phase_overflow();
      t_startup();
      wrap_up();
   end
endmodule // cm_lock_status_bench

/* verilog/cm_activity.sv */
// Toggle monitor for one clock pin seen from the system clock.
// Assumes the pin is asynchronous; it passes three flip-flops first.
`timescale 1ns/1ps
module cm_activity
   import cm_pkg::*;
#(
   parameter int STOP_CYCLES = CM_STOP_CYCLES
)(
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      rise,
   output logic      stopped
);
   // ********************************************************************
   // Synchroniser and change filter
   // ********************************************************************
   logic [2:0]  sync_q;          // Three-stage chain
   logic        level_q;         // Accepted level
   logic        level_d;
   logic        rise_q;          // One-cycle pulse on accepted rise
   logic        rise_d;
   logic [15:0] idle_q;          // Cycles since last accepted change
   logic [15:0] idle_d;
   logic        stop_q;
   logic        stop_d;

   // Next values; stage 1 is read only by stage 2
   always_comb
   begin
      level_d = level_q;
      if (sync_q[1] == sync_q[2])
      begin
         level_d = sync_q[2];
      end
      rise_d = level_d & ~level_q;
      // A change restarts the silence count
      if (level_d != level_q)
      begin
         idle_d = 16'h0000;
      end
      else if (idle_q < 16'(STOP_CYCLES))
      begin
         idle_d = idle_q + 16'h0001;
      end
      else
      begin
         idle_d = idle_q;
      end
      stop_d = (idle_d >= 16'(STOP_CYCLES));
   end

   // Registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_q  <= 3'h0;
         level_q <= 1'b0;
         rise_q  <= 1'b0;
         idle_q  <= 16'h0000;
         stop_q  <= 1'b0;
      end
      else
      begin
         sync_q  <= {sync_q[1:0], pin};
         level_q <= level_d;
         rise_q  <= rise_d;
         idle_q  <= idle_d;
         stop_q  <= stop_d;
      end
   end

   assign rise    = rise_q;
   assign stopped = stop_q;
endmodule // cm_activity

/* verilog/cm_lock_status.sv */
// Lock, status and startup-hold logic of an on-chip clock manager.
// Assumes clock pins are asynchronous to mclk and user step strobes are not.
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module cm_lock_status
   import cm_pkg::*;
#(
   parameter int TAP_MAX      = CM_TAP_MAX,
   parameter int LOCK_MATCHES = CM_LOCK_MATCHES
)(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        cm_reset,
   input  wire logic        ref_clock_input,
   input  wire logic        feedback_clock_input,
   input  wire logic        synth_clock_output,
   input  wire logic        synth_clock_output_inverted,
   input  wire logic        ps_step,
   input  wire logic        ps_increment,
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   output logic             lock_indicator,
   output logic [7:0]       status,
   output logic             user_mode,
   output logic             irq
);
   // ********************************************************************
   // Reset and clock monitors
   // ********************************************************************
   logic       rst_n;            // Either reset returns the whole block to its reset values
   logic [3:0] pins;             // ref, feedback, synth, synth inverted
   logic [3:0] rise_w;           // Accepted rising edges
   logic [3:0] stop_w;           // Silence detected

   assign rst_n = reset_n & ~cm_reset;
   assign pins  = {synth_clock_output_inverted, synth_clock_output,
                   feedback_clock_input, ref_clock_input};

   // One monitor per clock pin
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_mon
         cm_activity #(.STOP_CYCLES(CM_STOP_CYCLES)) u_mon (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .pin     (pins[gi]),
            .rise    (rise_w[gi]),
            .stopped (stop_w[gi])
         );
      end
   endgenerate

   // ********************************************************************
   // Delay loop, lock and phase shifter
   // ********************************************************************
   logic [7:0]  tap_q;           // Delay taps in use
   logic [7:0]  tap_d;
   logic [7:0]  gap_q;           // Cycles since last reference edge
   logic [7:0]  gap_d;
   logic [7:0]  gap_now;         // Measured feedback lag
   logic [3:0]  match_q;         // Consecutive aligned compares
   logic [3:0]  match_d;
   logic        lock_q;
   logic        lock_d;
   logic [8:0]  ps_q;            // Signed phase shift amount
   logic [8:0]  ps_d;
   logic        ps_ovf_q;        // Shift pushed past its bound
   logic        ps_ovf_d;

   always_comb
   begin
      gap_d    = rise_w[0] ? 8'h00 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
      gap_now  = rise_w[0] ? 8'h00 : gap_q;
      tap_d    = tap_q;
      match_d  = match_q;
      ps_d     = ps_q;
      ps_ovf_d = ps_ovf_q;
      // compare feedback lag against the taps
      if (rise_w[1])
      begin
         if (gap_now == tap_q)
         begin
            if (match_q != 4'(LOCK_MATCHES))
            begin
               match_d = match_q + 4'h1;
            end
         end
         else
         begin
            match_d = 4'h0;
            // Walk one tap toward alignment; stops at the last tap
            if ((gap_now > tap_q) && (tap_q != 8'(TAP_MAX)))
            begin
               tap_d = tap_q + 8'h01;
            end
            else if (gap_now < tap_q)
            begin
               tap_d = tap_q - 8'h01;
            end
         end
      end
      // A stopped reference can never be in phase
      if (stop_w[0])
      begin
         match_d = 4'h0;
      end
      lock_d = (match_d == 4'(LOCK_MATCHES));
      if (ps_step && ps_increment)
      begin
         ps_ovf_d = ($signed(ps_q) == CM_PS_LIMIT);
         if (!ps_ovf_d)
         begin
            ps_d = ps_q + 9'h001;
         end
      end
      else if (ps_step)
      begin
         ps_ovf_d = ($signed(ps_q) == -CM_PS_LIMIT);
         if (!ps_ovf_d)
         begin
            ps_d = ps_q - 9'h001;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tap_q    <= 8'h00;
         gap_q    <= 8'h00;
         match_q  <= 4'h0;
         lock_q   <= 1'b0;
         ps_q     <= 9'h000;
         ps_ovf_q <= 1'b0;
      end
      else
      begin
         tap_q    <= tap_d;
         gap_q    <= gap_d;
         match_q  <= match_d;
         lock_q   <= lock_d;
         ps_q     <= ps_d;
         ps_ovf_q <= ps_ovf_d;
      end
   end

   // ********************************************************************
   // Status bus and startup hold
   // ********************************************************************
   logic [6:0] ctrl_q;           // Options written by software
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic       start_q;          // One-cycle start pulse
   logic       user_q;
   logic       user_w;
   logic [2:0] cyc_w;
   logic       stall_w;

   always_comb
   begin
      status_d = 8'h00;
      status_d[CM_SB_PS_OVF] = ps_ovf_q | (tap_q == 8'(TAP_MAX));
      status_d[CM_SB_REF_STOP] = stop_w[0] & ctrl_q[CM_CTRL_FB_CONN] & ctrl_q[CM_CTRL_DLL];
      status_d[CM_SB_FS_STOP] = (stop_w[2] | stop_w[3]) & ctrl_q[CM_CTRL_FS];
      status_d[7:3] = 5'h00;
   end

   // wait option and cycle from software
   cm_startup u_start (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .start      (start_q),
      .wait_en    (ctrl_q[CM_CTRL_WAIT]),
      .wait_cycle (ctrl_q[CM_CTRL_CYC_LSB +: 3]),
      .lock       (lock_q),
      .cycle      (cyc_w),
      .stalled    (stall_w),
      .user_mode  (user_w)
   );

   // ********************************************************************
   // Interrupts and Avalon-MM slave
   // ********************************************************************
   logic [CM_IRQ_W-1:0] ev;      // Event pulses
   logic [CM_IRQ_W-1:0] ist_q;   // Sticky status
   logic [CM_IRQ_W-1:0] ist_d;
   logic [CM_IRQ_W-1:0] imask_q;
   logic [CM_IRQ_W-1:0] imask_d;
   logic [6:0]          ctrl_d;
   logic                start_d;
   logic                wait_q;
   logic                wait_d;
   logic [31:0]         rdata_q;
   logic [31:0]         rdata_d;
   logic                irq_q;
   logic                req;
   logic                fire;     // Edge at which the access completes

   always_comb
   begin
      ev[CM_EV_LOCK_UP]   = lock_d & ~lock_q;
      ev[CM_EV_LOCK_DOWN] = ~lock_d & lock_q;
      ev[CM_EV_PS_OVF]    = status_d[CM_SB_PS_OVF] & ~status_q[CM_SB_PS_OVF];
      ev[CM_EV_REF_STOP]  = status_d[CM_SB_REF_STOP] & ~status_q[CM_SB_REF_STOP];
      ev[CM_EV_FS_STOP]   = status_d[CM_SB_FS_STOP] & ~status_q[CM_SB_FS_STOP];
      req     = read | write;
      fire    = req & ~wait_q;
      // One wait state, then a single completing cycle
      wait_d  = ~(req & wait_q);
      ctrl_d  = ctrl_q;
      imask_d = imask_q;
      start_d = 1'b0;
      ist_d   = ist_q;
      rdata_d = rdata_q;
      if (req && wait_q)
      begin
         case (address)
            CM_OFS_CTRL:     rdata_d = {25'h0, ctrl_q};
            CM_OFS_STATUS:   rdata_d = {18'h0, user_q, stall_w, cyc_w, lock_q, status_q};
            CM_OFS_IRQ_STAT: rdata_d = {27'h0, ist_q};
            CM_OFS_IRQ_MASK: rdata_d = {27'h0, imask_q};
            CM_OFS_PHASE:    rdata_d = {15'h0, ps_q, tap_q};
            default:         rdata_d = 32'h0000_0000;
         endcase
      end
      if (fire && write && (address == CM_OFS_CTRL))
      begin
         ctrl_d  = writedata[6:0];
         start_d = writedata[CM_CTRL_START];
      end
      if (fire && write && (address == CM_OFS_IRQ_MASK))
      begin
         imask_d = writedata[CM_IRQ_W-1:0];
      end
      // Read clears only the bits it reported; an event after the snapshot still lands
      if (fire && read && (address == CM_OFS_IRQ_STAT))
      begin
         ist_d = (ist_q & ~rdata_q[CM_IRQ_W-1:0]) | ev;
      end
      else
      begin
         ist_d = ist_q | ev;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q   <= CM_CTRL_RESET;
         imask_q  <= '0;
         ist_q    <= '0;
         start_q  <= 1'b0;
         wait_q   <= 1'b1;
         rdata_q  <= 32'h0000_0000;
         irq_q    <= 1'b0;
         status_q <= 8'h00;
         user_q   <= 1'b0;
      end
      else
      begin
         ctrl_q   <= ctrl_d;
         imask_q  <= imask_d;
         ist_q    <= ist_d;
         start_q  <= start_d;
         wait_q   <= wait_d;
         rdata_q  <= rdata_d;
         irq_q    <= |(ist_d & imask_d);
         status_q <= status_d;
         user_q   <= user_w;
      end
   end

   assign readdata       = rdata_q;
   assign waitrequest    = wait_q;
   assign lock_indicator = lock_q;
   assign status         = status_q;
   assign user_mode      = user_q;
   assign irq            = irq_q;

   // ********************************************************************
   // Checks
   // ********************************************************************
   a_reset_clears:
   assert property (@(posedge mclk) !rst_n |-> !lock_q && (tap_q == 8'h00))
      else $error("reset left lock or taps set");
   a_lock_cause:
   assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(lock_q) |-> $past(rise_w[1]) && !$past(stop_w[0]))
      else $error("lock rose without an aligned feedback edge");
   a_ps_overflow:
   assert property (@(posedge mclk) disable iff (!rst_n)
      ps_step && ps_increment && ($signed(ps_q) == CM_PS_LIMIT) |=> ##1 status_q[0])
      else $error("shift past bound not flagged");
   a_taps_full:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (tap_q == 8'(TAP_MAX)) |=> status_q[0])
      else $error("full taps not flagged");
   a_ref_stopped:
   assert property (@(posedge mclk) disable iff (!rst_n)
      stop_w[0] && ctrl_q[CM_CTRL_FB_CONN] && ctrl_q[CM_CTRL_DLL] |=> status_q[1])
      else $error("stopped reference not flagged");
   a_fs_only_quiet:
   assert property (@(posedge mclk) disable iff (!rst_n)
      !ctrl_q[CM_CTRL_DLL] |=> !status_q[1])
      else $error("bit 1 set without delay-loop outputs");
   a_synth_stopped:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (stop_w[2] || stop_w[3]) && ctrl_q[CM_CTRL_FS] |=> status_q[2])
      else $error("stopped synthesized clock not flagged");
   a_reserved_zero:
   assert property (@(posedge mclk) disable iff (!rst_n) status_q[7:3] == 5'h00)
      else $error("reserved status bits set");
   a_wait_lock:
   assert property (@(posedge mclk) disable iff (!rst_n)
      stall_w |=> !user_q [*2])
      else $error("user mode entered while stalled");
   c_lock_up:  cover property (@(posedge mclk) disable iff (!rst_n) $rose(lock_q));
   c_user_on:  cover property (@(posedge mclk) disable iff (!rst_n) $rose(user_q));
   c_ovf_seen: cover property (@(posedge mclk) disable iff (!rst_n) $rose(status_q[0]));
   c_irq_seen: cover property (@(posedge mclk) disable iff (!rst_n) $rose(irq_q));
endmodule // cm_lock_status

/* verilog/cm_pkg.sv */
// Shared constants of the clock manager lock and status block.
// Assumes a single 100 MHz system clock and an Avalon-MM register slave.
package cm_pkg;
   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam int CM_CLK_PERIOD_NS  = 10;    // System clock period
   localparam int CM_STOP_TIME_NS   = 1000;  // Silence that marks a stopped clock
   localparam int CM_STOP_CYCLES    = (CM_STOP_TIME_NS + CM_CLK_PERIOD_NS - 1)
                                      / CM_CLK_PERIOD_NS;
   localparam int CM_LOCK_MATCHES   = 4;     // Aligned compares before lock
   localparam int CM_TAP_MAX        = 255;   // Every delay tap active
   localparam int CM_PS_LIMIT       = 255;   // Phase shift bound in 1/256 steps
   localparam int CM_STARTUP_CYCLES = 6;     // Cycles of the startup phase
   localparam int CM_STEP_DIV       = 8;     // System clocks per startup cycle

   // ********************************************************************
   // Register map (byte addresses)
   // ********************************************************************
   localparam logic [4:0] CM_OFS_CTRL     = 5'h00;
   localparam logic [4:0] CM_OFS_STATUS   = 5'h04;
   localparam logic [4:0] CM_OFS_IRQ_STAT = 5'h08;
   localparam logic [4:0] CM_OFS_IRQ_MASK = 5'h0c;
   localparam logic [4:0] CM_OFS_PHASE    = 5'h10;

   // Control fields
   localparam int CM_CTRL_WAIT    = 0;       // Startup waits for lock
   localparam int CM_CTRL_FB_CONN = 1;       // Feedback clock connected
   localparam int CM_CTRL_DLL     = 2;       // Delay-loop outputs in use
   localparam int CM_CTRL_FS      = 3;       // Frequency synthesizer in use
   localparam int CM_CTRL_CYC_LSB = 4;       // Lock wait cycle select, 3 bits
   localparam int CM_CTRL_START   = 7;       // Write 1 starts the startup phase
   localparam logic [6:0] CM_CTRL_RESET = 7'h0e;

   // Status bus bits
   localparam int CM_SB_PS_OVF   = 0;
   localparam int CM_SB_REF_STOP = 1;
   localparam int CM_SB_FS_STOP  = 2;

   // Interrupt event bits
   localparam int CM_IRQ_W        = 5;
   localparam int CM_EV_LOCK_UP   = 0;
   localparam int CM_EV_LOCK_DOWN = 1;
   localparam int CM_EV_PS_OVF    = 2;
   localparam int CM_EV_REF_STOP  = 3;
   localparam int CM_EV_FS_STOP   = 4;

   // Startup sequencer states
   typedef enum logic [1:0] {CM_SS_IDLE, CM_SS_STEP, CM_SS_DONE} cm_start_state_type;
endpackage

/* verilog/cm_startup.sv */
// Startup-phase sequencer with an optional hold for lock.
// Assumes lock comes from the same clock domain.
`timescale 1ns/1ps
module cm_startup
   import cm_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       start,
   input  wire logic       wait_en,
   input  wire logic [2:0] wait_cycle,
   input  wire logic       lock,
   output logic [2:0]      cycle,
   output logic            stalled,
   output logic            user_mode
);
   // ********************************************************************
   // Step divider and sequencer
   // ********************************************************************
   cm_start_state_type state_q;
   cm_start_state_type state_d;
   logic [3:0] div_q;            // Divides mclk down to startup cycles
   logic [3:0] div_d;
   logic [2:0] cyc_q;
   logic [2:0] cyc_d;
   logic       hold;             // Selected cycle reached without lock

   always_comb
   begin
      state_d = state_q;
      cyc_d   = cyc_q;
      div_d   = (div_q == 4'(CM_STEP_DIV - 1)) ? 4'h0 : div_q + 4'h1;
      hold    = (state_q == CM_SS_STEP) && wait_en && (cyc_q == wait_cycle) && !lock;
      case (state_q)
         CM_SS_IDLE:
         begin
            cyc_d = 3'h0;
            if (start)
            begin
               state_d = CM_SS_STEP;
            end
         end
         CM_SS_STEP:
         begin
            // wait only when the option is set
            if ((div_q == 4'h0) && !hold)
            begin
               if (cyc_q == 3'(CM_STARTUP_CYCLES - 1))
               begin
                  state_d = CM_SS_DONE;
               end
               else
               begin
                  cyc_d = cyc_q + 3'h1;
               end
            end
         end
         CM_SS_DONE:
         begin
            state_d = CM_SS_DONE;
         end
         default:
         begin
            state_d = CM_SS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= CM_SS_IDLE;
         div_q   <= 4'h0;
         cyc_q   <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         div_q   <= div_d;
         cyc_q   <= cyc_d;
      end
   end

   assign cycle     = cyc_q;
   assign stalled   = hold;
   assign user_mode = (state_q == CM_SS_DONE);

   // ********************************************************************
   // Checks
   // ********************************************************************
   a_hold_no_user:
   assert property (@(posedge mclk) disable iff (!rst_n)
      hold |=> (state_q == CM_SS_STEP) && (cyc_q == $past(cyc_q)))
      else $error("startup moved on while waiting for lock");
   a_nowait_runs:
   assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(state_q == CM_SS_STEP) && !wait_en |-> ##[1:60] (state_q == CM_SS_DONE))
      else $error("startup stalled with wait option off");
   c_stall_seen: cover property (@(posedge mclk) disable iff (!rst_n) hold ##1 !hold);
endmodule // cm_startup
